/* rtl/sfpst_seq.v */
// power, reset and busy-time sequencer of a serial flash
// Notes on behaviour
// - data output stays high impedance after power-up and after reset
// - an instruction starts only at a chip select falling edge
// - at each select fall, idle clock high picks mode 3, low mode 0
// - during power-on reset all operations and commands are ignored
// - program or erase refused until the 3 ms power-up delay ends
// - after the delay: standby with select high, active with select low
// - ultra deep power-down reached within 3 us of select rising
// - a select low pulse of at least 20 ns wakes ultra deep power-down; the code needs the low sampled by core_clk, sure from 100 ns
// - resume command returns to standby within 8 us of select rising
// - page program 3 ms, page erase 25 ms, 4K block erase 75 ms
// - security register program completes within 950 us
// - status write completes within 40 ms, device busy meanwhile
`timescale 1ns/1ps
`include "sfpst_map.vh"
module sfpst_seq #(
    parameter CNT_W      = 20,
    parameter CYC_PUW    = `SFPST_CYC_PUW,
    parameter CYC_VCSL   = `SFPST_CYC_VCSL,
    parameter CYC_EUDPD  = `SFPST_CYC_EUDPD,
    parameter CYC_XUDPD  = `SFPST_CYC_XUDPD,
    parameter CYC_RDPD   = `SFPST_CYC_RDPD,
    parameter CYC_PP     = `SFPST_CYC_PP,
    parameter CYC_PE     = `SFPST_CYC_PE,
    parameter CYC_BLKE   = `SFPST_CYC_BLKE,
    parameter CYC_OTPP   = `SFPST_CYC_OTPP,
    parameter CYC_WRSR   = `SFPST_CYC_WRSR
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rstn,
    // spi pins
    input  wire       chip_select_n,
    input  wire       sclk,
    output wire       so_out,
    output wire       so_oe,
    // decoded command from the spi front end
    input  wire [2:0] op_code,
    input  wire       op_valid,
    input  wire       resume_cmd,
    input  wire       so_data,
    input  wire       so_drive,
    // status
    output reg  [2:0] power_state,
    output reg        spi_mode3,
    output reg        cmd_accept,
    output reg        op_refused,
    output reg        busy,
    output reg        puw_done,
    output reg        read_ready
);
    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    wire cs_s;
    wire cs_rise;
    wire cs_fall;
    wire ck_s;
    sfpst_sync u_cs (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (chip_select_n),
        .sync_out (cs_s),
        .rise     (cs_rise),
        .fall     (cs_fall)
    );
    sfpst_sync u_ck (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (sclk),
        .sync_out (ck_s),
        .rise     (),
        .fall     ()
    );
    // -------------------------------------------------------------
    // busy-time lookup
    // -------------------------------------------------------------
    function [CNT_W-1:0] op_limit;
        input [2:0] op;
        begin
            case (op)
                `SFPST_OP_PP:   op_limit = CYC_PP[CNT_W-1:0];
                `SFPST_OP_PE:   op_limit = CYC_PE[CNT_W-1:0];
                `SFPST_OP_BLKE: op_limit = CYC_BLKE[CNT_W-1:0];
                `SFPST_OP_OTPP: op_limit = CYC_OTPP[CNT_W-1:0];
                `SFPST_OP_WRSR: op_limit = CYC_WRSR[CNT_W-1:0];
                default:        op_limit = {CNT_W{1'b0}};
            endcase
        end
    endfunction
    function is_write_op;
        input [2:0] op;
        begin
            is_write_op = (op >= `SFPST_OP_PP) && (op <= `SFPST_OP_WRSR);
        end
    endfunction
    // -------------------------------------------------------------
    // state and counters
    // -------------------------------------------------------------
    reg [CNT_W-1:0] por_cnt_r;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] lim_r;
    reg             armed_r;
    reg             udpd_pend_r;
    reg             rdpd_pend_r;
    reg             so_oe_r;
    // select sync latency and one spare cycle come off the entry count,
    // so power-down is reached within the limit measured at the pin
    localparam integer EU_LIM = (CYC_EUDPD > 6) ? CYC_EUDPD - 6 : 0;
    wire            cnt_end = (cnt_r >= lim_r);
    wire            in_frame = armed_r & ~cs_s;
    // output floats unless a live, framed read drives it
    assign so_oe  = so_oe_r;
    assign so_out = so_oe_r & so_data;
    // -------------------------------------------------------------
    // power-up delay counter
    // -------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rstn) begin
            por_cnt_r  <= {CNT_W{1'b0}};
            puw_done   <= 1'b0;
            read_ready <= 1'b0;
        end else begin
            // keeps counting until both limits are met, whichever is longer
            if (!puw_done || !read_ready)
                por_cnt_r <= por_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            if (por_cnt_r >= CYC_VCSL[CNT_W-1:0])
                read_ready <= 1'b1;
            if (por_cnt_r >= CYC_PUW[CNT_W-1:0])
                puw_done <= 1'b1;
        end
    end
    // -------------------------------------------------------------
    // main sequencer
    // -------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rstn) begin
            power_state <= `SFPST_ST_POR;
            spi_mode3   <= 1'b0;
            armed_r     <= 1'b0;
            cmd_accept  <= 1'b0;
            op_refused  <= 1'b0;
            busy        <= 1'b0;
            cnt_r       <= {CNT_W{1'b0}};
            lim_r       <= {CNT_W{1'b0}};
            udpd_pend_r <= 1'b0;
            rdpd_pend_r <= 1'b0;
            so_oe_r     <= 1'b0;
        end else begin
            cmd_accept <= 1'b0;
            op_refused <= 1'b0;
            so_oe_r    <= in_frame & so_drive &
                          (power_state == `SFPST_ST_ACT);
            if (cs_fall) begin
                spi_mode3 <= ck_s;
                armed_r   <= 1'b1;
            end
            if (cs_rise)
                armed_r <= 1'b0;
            case (power_state)
                `SFPST_ST_POR: begin
                    // commands ignored; frames open before the end
                    // of the delay are not armed
                    armed_r <= 1'b0;
                    if (puw_done)
                        power_state <= cs_s ? `SFPST_ST_STBY
                                            : `SFPST_ST_ACT;
                end
                `SFPST_ST_STBY: begin
                    if (cs_fall)
                        power_state <= `SFPST_ST_ACT;
                    if (rdpd_pend_r && cnt_end) begin
                        rdpd_pend_r <= 1'b0;
                    end else if (rdpd_pend_r)
                        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                `SFPST_ST_ACT: begin
                    if (op_valid && in_frame) begin
                        if (is_write_op(op_code) && !puw_done) begin
                            op_refused <= 1'b1;
                        end else begin
                            cmd_accept <= 1'b1;
                            if (is_write_op(op_code)) begin
                                lim_r <= op_limit(op_code);
                                busy  <= 1'b1;
                            end
                            if (op_code == `SFPST_OP_UDPD)
                                udpd_pend_r <= 1'b1;
                        end
                    end
                    if (resume_cmd && in_frame)
                        rdpd_pend_r <= 1'b1;
                    if (cs_rise) begin
                        cnt_r <= {CNT_W{1'b0}};
                        if (udpd_pend_r) begin
                            udpd_pend_r <= 1'b0;
                            lim_r <= EU_LIM[CNT_W-1:0];
                            power_state <= `SFPST_ST_ENTU;
                        end else if (busy)
                            power_state <= `SFPST_ST_BUSY;
                        else begin
                            if (rdpd_pend_r)
                                lim_r <= CYC_RDPD[CNT_W-1:0];
                            power_state <= `SFPST_ST_STBY;
                        end
                    end
                end
                `SFPST_ST_BUSY: begin
                    // commands during busy are not taken
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (cnt_end) begin
                        busy <= 1'b0;
                        power_state <= cs_s ? `SFPST_ST_STBY
                                            : `SFPST_ST_ACT;
                    end
                end
                `SFPST_ST_ENTU: begin
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (cnt_end)
                        power_state <= `SFPST_ST_UDPD;
                end
                `SFPST_ST_UDPD: begin
                    armed_r <= 1'b0;
                    // one sampled low wakes it; a low pulse shorter than the 100 ns core_clk period can be missed
                    if (cs_fall) begin
                        cnt_r <= {CNT_W{1'b0}};
                        lim_r <= CYC_XUDPD[CNT_W-1:0];
                        power_state <= `SFPST_ST_WAKE;
                    end
                end
                `SFPST_ST_WAKE: begin
                    armed_r <= 1'b0;
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (cnt_end && cs_s)
                        power_state <= `SFPST_ST_STBY;
                end
                default: power_state <= `SFPST_ST_POR;
            endcase
        end
    end
endmodule // sfpst_seq

/* rtl/sfpst_map.vh */
// timing constants and state codes for the flash power-state sequencer
`ifndef SFPST_MAP_VH
`define SFPST_MAP_VH
// -----------------------------------------------------------------
// clock and times
// -----------------------------------------------------------------
`define SFPST_CLK_KHZ        10000
`define SFPST_T_VCSL_US      70
`define SFPST_T_PUW_MS       3
`define SFPST_T_EUDPD_US     3
`define SFPST_T_XUDPD_US     70
`define SFPST_T_RDPD_US      8
`define SFPST_T_PP_MS        3
`define SFPST_T_PE_MS        25
`define SFPST_T_BLKE_MS      75
`define SFPST_T_OTPP_US      950
`define SFPST_T_WRSR_MS      40
`define SFPST_T_WRSR_TYP_MS  20
// -----------------------------------------------------------------
// cycle counts (longest times round down)
// -----------------------------------------------------------------
`define SFPST_CYC_PUW   (`SFPST_T_PUW_MS * `SFPST_CLK_KHZ)
`define SFPST_CYC_VCSL  (`SFPST_T_VCSL_US * `SFPST_CLK_KHZ / 1000)
`define SFPST_CYC_EUDPD (`SFPST_T_EUDPD_US * `SFPST_CLK_KHZ / 1000)
`define SFPST_CYC_XUDPD (`SFPST_T_XUDPD_US * `SFPST_CLK_KHZ / 1000)
`define SFPST_CYC_RDPD  (`SFPST_T_RDPD_US * `SFPST_CLK_KHZ / 1000)
`define SFPST_CYC_PP    (`SFPST_T_PP_MS * `SFPST_CLK_KHZ)
`define SFPST_CYC_PE    (`SFPST_T_PE_MS * `SFPST_CLK_KHZ)
`define SFPST_CYC_BLKE  (`SFPST_T_BLKE_MS * `SFPST_CLK_KHZ)
`define SFPST_CYC_OTPP  (`SFPST_T_OTPP_US * `SFPST_CLK_KHZ / 1000)
`define SFPST_CYC_WRSR  (`SFPST_T_WRSR_MS * `SFPST_CLK_KHZ)
// -----------------------------------------------------------------
// operation codes on op_code
// -----------------------------------------------------------------
`define SFPST_OP_NONE   3'h0
`define SFPST_OP_READ   3'h1
`define SFPST_OP_PP     3'h2
`define SFPST_OP_PE     3'h3
`define SFPST_OP_BLKE   3'h4
`define SFPST_OP_OTPP   3'h5
`define SFPST_OP_WRSR   3'h6
`define SFPST_OP_UDPD   3'h7
// -----------------------------------------------------------------
// power states
// -----------------------------------------------------------------
`define SFPST_ST_POR    3'h0
`define SFPST_ST_STBY   3'h1
`define SFPST_ST_ACT    3'h2
`define SFPST_ST_BUSY   3'h3
`define SFPST_ST_ENTU   3'h4
`define SFPST_ST_UDPD   3'h5
`define SFPST_ST_WAKE   3'h6
`endif

/* rtl/sfpst_sync.v */
// two-flop synchroniser with edge detect on the second stage
`timescale 1ns/1ps
module sfpst_sync (
    // clock and reset
    input  wire core_clk,
    input  wire rstn,
    // async level in
    input  wire async_in,
    // synchronised level and edges
    output reg  sync_out,
    output reg  rise,
    output reg  fall
);
    reg meta_r;
    reg last_r;
    // -------------------------------------------------------------
    // first flop feeds only the second
    // -------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rstn) begin
            meta_r   <= 1'b1;
            sync_out <= 1'b1;
            last_r   <= 1'b1;
            rise     <= 1'b0;
            fall     <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
            last_r   <= sync_out;
            rise     <= sync_out & ~last_r;
            fall     <= ~sync_out & last_r;
        end
    end
endmodule // sfpst_sync

/* tb/sfpst_seq_props.sv */
// port checks for the flash power-state sequencer
`timescale 1ns/1ps
`include "sfpst_map.vh"
module sfpst_seq_props #(
    parameter CYC_PUW   = `SFPST_CYC_PUW,
    parameter CYC_EUDPD = `SFPST_CYC_EUDPD,
    parameter CYC_XUDPD = `SFPST_CYC_XUDPD,
    parameter BZ_LIM    = `SFPST_CYC_BLKE
) (
    // clock and reset
    input wire       core_clk,
    input wire       rstn,
    // pins and strobes
    input wire       sclk,
    input wire       so_oe,
    input wire       op_valid,
    // status
    input wire [2:0] power_state,
    input wire       spi_mode3,
    input wire       cmd_accept,
    input wire       busy,
    input wire       puw_done
);
    localparam int EU_MAX = CYC_EUDPD + 2;
    localparam BZ_MAX = BZ_LIM + 12;
    reg [31:0] up_r;
    reg [31:0] bz_r;
    reg [31:0] wk_r;
    // ------------------------------------------------
    // cycle counters, wide so they never wrap in a run
    // ------------------------------------------------
    always @(posedge core_clk) begin
        up_r <= rstn ? up_r + 32'h1 : 32'h0;
        bz_r <= (rstn && busy) ? bz_r + 32'h1 : 32'h0;
        wk_r <= (rstn && power_state == 3'h6) ? wk_r + 32'h1 : 32'h0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    hiz_reset_a: assert property (disable iff (1'b0)
        !rstn |=> !so_oe && power_state == 3'h0) else $error("not quiet");
    por_quiet_a: assert property (power_state == 3'h0 |->
        !cmd_accept && !busy) else $error("activity in power-on reset");
    accept_src_a: assert property (cmd_accept |-> $past(op_valid) &&
        $past(power_state) == 3'h2) else $error("accept outside frame");
    mode_pick_a: assert property ($changed(spi_mode3) |->
        spi_mode3 == sclk) else $error("mode not from idle clock");
    puw_time_a: assert property ($rose(puw_done) |->
        up_r >= CYC_PUW && up_r <= CYC_PUW + 2) else $error("bad delay");
    udpd_entry_a: assert property ($rose(power_state == 3'h4) |->
        ##[1:EU_MAX] power_state == 3'h5) else $error("late power-down");
    wake_wait_a: assert property ($fell(power_state == 3'h6) |->
        wk_r >= CYC_XUDPD - 1) else $error("wake wait cut short");
    busy_bound_a: assert property (bz_r <= BZ_MAX)
        else $error("busy too long");
endmodule // sfpst_seq_props
// one bound that no single operation can exceed, whatever the overrides
bind sfpst_seq sfpst_seq_props #(.BZ_LIM(
    (CYC_PP > CYC_PE ? CYC_PP : CYC_PE) +
    (CYC_BLKE > CYC_WRSR ? CYC_BLKE : CYC_WRSR) + CYC_OTPP))
    chk_u (.core_clk(core_clk), .rstn(rstn), .sclk(sclk), .so_oe(so_oe),
    .op_valid(op_valid), .power_state(power_state), .spi_mode3(spi_mode3),
    .cmd_accept(cmd_accept), .busy(busy), .puw_done(puw_done));

/* tb/sfpst_host.sv */
// spi host model driving select and the link clock
`timescale 1ns/1ps
module sfpst_host (
    // spi pins
    output reg chip_select_n,
    output reg sclk
);
    reg run;
    reg idle;
    // link clock runs only inside a frame, phase free of core_clk
    initial begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        run = 1'b0;
        idle = 1'b0;
        #37;
        forever #400 if (run) sclk = ~sclk;
    end
    // idle level settles before the fall so the mode sample is clean
    task open_frame(input bit m3);
        begin
            idle = m3;
            sclk = m3;
            #130 chip_select_n = 1'b0;
            #900 run = 1'b1;
        end
    endtask
    task close_frame;
        begin
            run = 1'b0;
            sclk = idle;
            #170 chip_select_n = 1'b1;
        end
    endtask
    task wake_pulse;
        begin
            #30 chip_select_n = 1'b0;
            #250 chip_select_n = 1'b1;
        end
    endtask
endmodule // sfpst_host

/* tb/spi_flash_power_state_timing_test.sv */
// self-checking bench for the flash power-state sequencer
`timescale 1ns/1ps
`include "sfpst_map.vh"
module spi_flash_power_state_timing_test;
    localparam XU   = `SFPST_CYC_XUDPD;
    localparam EU   = `SFPST_CYC_EUDPD;
    localparam PP   = 40;
    localparam PE   = 60;
    localparam BLKE = 80;
    localparam WRSR = 100;
    reg        core_clk;
    reg        rstn;
    reg  [2:0] op_code;
    reg        op_valid;
    reg        resume_cmd;
    reg        so_data;
    reg        so_drive;
    wire       chip_select_n;
    wire       sclk;
    wire       so_out;
    wire       so_oe;
    wire [2:0] power_state;
    wire       spi_mode3;
    wire       cmd_accept;
    wire       op_refused;
    wire       busy;
    wire       puw_done;
    wire       read_ready;
    integer    bad_count;
    integer    tests_run;
    integer    n;
    integer    lim [1:6];
    integer    q [$];
    bit        m3;
    // ------------------------------------------------
    // host model and design
    // ------------------------------------------------
    sfpst_host host_u (.chip_select_n(chip_select_n), .sclk(sclk));
    sfpst_seq #(.CYC_PP(PP), .CYC_PE(PE), .CYC_BLKE(BLKE),
        .CYC_WRSR(WRSR)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .chip_select_n(chip_select_n),
        .sclk(sclk), .so_out(so_out), .so_oe(so_oe), .op_code(op_code),
        .op_valid(op_valid), .resume_cmd(resume_cmd), .so_data(so_data),
        .so_drive(so_drive), .power_state(power_state),
        .spi_mode3(spi_mode3), .cmd_accept(cmd_accept),
        .op_refused(op_refused),
        .busy(busy), .puw_done(puw_done), .read_ready(read_ready));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("Error %0t: saw %0h want %0h", $time, seen, exp);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(negedge core_clk);
    endtask
    task pulse(input [2:0] c, input a);
        begin
            op_code = c;
            op_valid = 1'b1;
            cyc(1);
            op_valid = 1'b0;
            chk(cmd_accept, a);
            chk(op_refused, 0);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // whole run is near 41000 cycles
    initial begin
        #6000000;
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        rstn = 1'b0;
        op_code = 3'h0;
        op_valid = 1'b0;
        resume_cmd = 1'b0;
        so_data = 1'b0;
        so_drive = 1'b0;
        bad_count = 0;
        tests_run = 0;
        lim = '{0, PP, PE, BLKE, `SFPST_CYC_OTPP, WRSR};
        q = '{2, 3, 4, 5, 6, 1};
        m3 = $urandom(65);
        cyc(4);
        chk(so_oe, 0);
        rstn = 1'b1;
        host_u.open_frame(1);
        cyc(1);
        pulse(3'h2, 0);
        host_u.close_frame;
        n = 0;
        while (!puw_done && n < `SFPST_CYC_PUW + 100) begin
            cyc(1);
            n = n + 1;
        end
        cyc(1);
        chk(power_state, 1);
        chk(read_ready, 1);
        $display("power-up done");
        foreach (q[i]) begin
            m3 = $urandom;
            host_u.open_frame(m3);
            cyc(6);
            chk(spi_mode3, m3);
            chk(power_state, 2);
            so_data = $urandom;
            so_drive = 1'b1;
            cyc(2);
            chk(so_oe, 1);
            chk(so_out, so_data);
            so_drive = 1'b0;
            pulse(q[i], 1);
            host_u.close_frame;
            n = 0;
            while (busy && n < lim[q[i]] + 100) begin
                cyc(1);
                n = n + 1;
            end
            chk(n >= lim[q[i]] && n <= lim[q[i]] + 6, 1);
            // a read leaves no busy time; select rise still needs syncing
            cyc(5);
            chk(power_state, 1);
            pulse(q[i], 0);
            $display("op %0d done", q[i]);
        end
        host_u.open_frame(0);
        cyc(6);
        pulse(3'h7, 1);
        host_u.close_frame;
        cyc(EU);
        chk(power_state, 5);
        host_u.wake_pulse;
        cyc(4);
        chk(power_state, 6);
        host_u.open_frame(0);
        cyc(6);
        pulse(3'h2, 0);
        host_u.close_frame;
        cyc(XU + 4);
        chk(power_state, 1);
        host_u.open_frame(1);
        cyc(6);
        resume_cmd = 1'b1;
        cyc(1);
        resume_cmd = 1'b0;
        host_u.close_frame;
        cyc(12);
        chk(power_state, 1);
        $display("power-down done");
        host_u.open_frame(1);
        cyc(8);
        so_drive = 1'b1;
        rstn = 1'b0;
        cyc(2);
        chk(so_oe, 0);
        rstn = 1'b1;
        host_u.close_frame;
        cyc(4);
        close_out;
    end
endmodule // spi_flash_power_state_timing_test
